/* File: pkg/dvo_pkg.sv */
// Package with constants for the delta velocity output block.
`default_nettype none
package dvo_pkg;
	localparam int unsigned DVO_ADDR_W = 8;
	localparam int unsigned DVO_DATA_W = 16;
	localparam int unsigned DVO_ACC_W = 32;
	localparam int unsigned DVO_SUM_W = 48;
	localparam logic [7:0] DVO_PAGE_ZERO = 8'h00;
	localparam logic [7:0] DVO_OFS_X_LOW = 8'h4c;
	localparam logic [7:0] DVO_OFS_X_HIGH = 8'h4e;
	localparam logic [7:0] DVO_OFS_Y_LOW = 8'h50;
	localparam logic [7:0] DVO_OFS_Y_HIGH = 8'h52;
	localparam logic [7:0] DVO_OFS_Z_LOW = 8'h54;
	localparam logic [7:0] DVO_OFS_Z_HIGH = 8'h56;
	localparam logic [7:0] DVO_OFS_TRIGGER = 8'h7c;
	localparam logic [7:0] DVO_OFS_PART_ID = 8'h7e;
	localparam logic [7:0] DVO_OFS_PAGE = 8'h00;
	localparam logic [7:0] DVO_OFS_DECIM = 8'h64;
	localparam logic [7:0] DVO_OFS_SCALE = 8'h66;
	// Arbitrary neutral identification value.
	localparam logic [15:0] DVO_PART_ID_VALUE = 16'h5aa5;
	localparam logic [15:0] DVO_DECIM_RESET = 16'h0000;
	localparam logic [15:0] DVO_DECIM_1HZ = 16'h1099;
	localparam logic [15:0] DVO_TRIGGER_VALUE = 16'h0000;
	localparam int unsigned DVO_FS_INTERNAL_SPS = 4250;
	localparam logic [31:0] DVO_SCALE_RESET = 32'h0000_0000;
	localparam int unsigned DVO_SYNC_STAGES = 3;
endpackage
`default_nettype wire

/* File: src/dvo_top.sv */
// Delta velocity integrator with its register page and burst trigger.
// Overview of operation
// - Each axis result is the sum over D samples of each sample plus its predecessor, scaled by 2^-16 as the upper 32 of the 48 sum bits.
// - D is the decimation setting plus one, and one result is produced per D samples.
// - The sample rate is 4250 SPS internally, or the external clock rate when that is selected.
// - The output range holds 8 g at the nominal rate with a 1 Hz update, decimation setting 0x1099.
// - Each axis is read as a high and a low 16-bit word forming one 32-bit two's complement value.
// - The high word is two's complement, zero meaning no change, one count being 400 m/sec over 2^15.
// - On page zero the x low word is at 0x4C and the x high word at 0x4E.
// - The y words are at 0x50 to 0x53 and the z words at 0x54 to 0x57 on the same page.
// - Reading the trigger register at 0x7C on page zero starts the multi-register read.
// - The part identifier at 0x7E returns a fixed value that may be read repeatedly.
// - A result is positive for a velocity increase along the axis and negative for a decrease.
// - Integration runs on samples before decimation, at the pre-decimation sample time.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dvo_top (
	input wire logic i_clock, // 40 MHz system clock
	input wire logic i_rst_n, // synchronous reset, active low
	input wire logic i_sample_valid, // one-cycle strobe with a new sample
	input wire logic signed [15:0] i_accel_x, // x acceleration sample
	input wire logic signed [15:0] i_accel_y, // y acceleration sample
	input wire logic signed [15:0] i_accel_z, // z acceleration sample
	input wire logic i_ext_clock, // external sample clock pin
	input wire logic i_ext_select, // high selects the external clock
	input wire logic [7:0] i_addr, // register byte address
	input wire logic [15:0] i_wdata, // register write data
	input wire logic i_wr, // write strobe
	input wire logic i_rd, // read strobe
	output logic [15:0] o_rdata, // read data, cycle after the strobe
	output logic o_burst_start, // one-cycle pulse starting a burst read
	output logic o_sample_tick, // one-cycle pulse per rising external clock edge while selected
	output logic o_result_valid // one-cycle pulse per new result
);
	logic [2:0] ext_sync_q;
	logic ext_level_q;
	logic [15:0] page_q;
	logic [15:0] decim_q;
	logic [31:0] scale_q;
	logic [15:0] count_q;
	logic [15:0] rdata_q;
	logic burst_q;
	logic valid_q;
	logic [15:0] prev_q [3];
	logic signed [47:0] sum_q [3];
	logic [31:0] result_q [3];
	logic signed [15:0] sample [3];
	logic page0;
	logic last_sample;
	logic ext_rise;
	logic [15:0] sel_word;
	assign sample[0] = i_accel_x;
	assign sample[1] = i_accel_y;
	assign sample[2] = i_accel_z;
	assign page0 = (page_q == 16'(dvo_pkg::DVO_PAGE_ZERO));
	// Greater-or-equal closes a period at once if the setting is lowered mid-period.
	assign last_sample = i_sample_valid && (count_q >= decim_q);
	// A new level counts only once the second and third stages agree on it.
	assign ext_rise = ext_sync_q[1] & ext_sync_q[2] & ~ext_level_q;

	function automatic logic [15:0] dvo_read_word(input logic [7:0] a, input logic p0);
		logic [15:0] w;
		w = 16'h0000;
		if (a == dvo_pkg::DVO_OFS_PAGE)
			w = page_q;
		else if (p0)
		begin
			case (a)
				dvo_pkg::DVO_OFS_X_LOW: w = result_q[0][15:0];
				dvo_pkg::DVO_OFS_X_HIGH: w = result_q[0][31:16];
				dvo_pkg::DVO_OFS_Y_LOW: w = result_q[1][15:0];
				dvo_pkg::DVO_OFS_Y_HIGH: w = result_q[1][31:16];
				dvo_pkg::DVO_OFS_Z_LOW: w = result_q[2][15:0];
				dvo_pkg::DVO_OFS_Z_HIGH: w = result_q[2][31:16];
				dvo_pkg::DVO_OFS_TRIGGER: w = dvo_pkg::DVO_TRIGGER_VALUE;
				dvo_pkg::DVO_OFS_PART_ID: w = dvo_pkg::DVO_PART_ID_VALUE;
				dvo_pkg::DVO_OFS_DECIM: w = decim_q;
				dvo_pkg::DVO_OFS_SCALE: w = scale_q[15:0];
				default: w = 16'h0000;
			endcase
		end
		return w;
	endfunction

	assign sel_word = dvo_read_word(i_addr, page0);

	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			ext_sync_q <= 3'b000;
			ext_level_q <= 1'b0;
			page_q <= 16'h0000;
			decim_q <= dvo_pkg::DVO_DECIM_RESET;
			scale_q <= dvo_pkg::DVO_SCALE_RESET;
			count_q <= 16'h0000;
			rdata_q <= 16'h0000;
			burst_q <= 1'b0;
			valid_q <= 1'b0;
		end
		else
		begin
			ext_sync_q <= {ext_sync_q[1:0], i_ext_clock};
			if (ext_sync_q[1] == ext_sync_q[2])
				ext_level_q <= ext_sync_q[2];
			if (i_wr && i_addr == dvo_pkg::DVO_OFS_PAGE)
				page_q <= i_wdata;
			// Result words are not writable; writes there fall through.
			if (i_wr && page0 && i_addr == dvo_pkg::DVO_OFS_DECIM)
				decim_q <= i_wdata;
			if (i_wr && page0 && i_addr == dvo_pkg::DVO_OFS_SCALE)
				scale_q <= {16'h0000, i_wdata};
			if (i_sample_valid)
				count_q <= last_sample ? 16'h0000 : 16'(count_q + 16'h0001);
			rdata_q <= i_rd ? sel_word : 16'h0000;
			burst_q <= i_rd && page0 && (i_addr == dvo_pkg::DVO_OFS_TRIGGER);
			valid_q <= last_sample;
		end
	end

	// The accumulators carry no reset: results are undefined until the second period ends, as the first sample pairs with an unset predecessor.
	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_axis
			logic signed [47:0] pair;
			logic signed [47:0] next_sum;
			assign pair = 48'(sample[g]) + 48'($signed(prev_q[g]));
			assign next_sum = (count_q == 16'h0000) ? pair : 48'(sum_q[g] + pair);
			always_ff @(posedge i_clock)
			begin
				if (i_sample_valid)
				begin
					prev_q[g] <= sample[g];
					sum_q[g] <= next_sum;
				end
				// Sign carries through, so a velocity increase reads positive.
				if (last_sample)
					result_q[g] <= next_sum[47:16];
			end
		end
	endgenerate

	assign o_rdata = rdata_q;
	assign o_burst_start = burst_q;
	assign o_sample_tick = ext_rise & i_ext_select;
	assign o_result_valid = valid_q;
endmodule // dvo_top
`default_nettype wire

/* File: tb/dvo_props.sv */
// Port checker for the delta velocity output block.
`timescale 1ns/1ps
`default_nettype none
module dvo_props (
	input wire logic i_clock, // clock
	input wire logic i_rst_n, // reset
	input wire logic [7:0] i_addr, // address
	input wire logic i_rd, // read
	input wire logic i_ext_select, // select
	input wire logic [15:0] o_rdata, // data
	input wire logic o_burst_start, // burst
	input wire logic o_sample_tick // tick
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 16'h0000)
		else $error("rdata not idle");
	a_part_id: assert property (i_rd && i_addr == 8'h7e |=> o_rdata == 16'h5aa5)
		else $error("id wrong");
	a_trig_data: assert property (i_rd && i_addr == 8'h7c |=> o_rdata == 16'h0000)
		else $error("trigger data");
	a_burst_read: assert property (i_rd && i_addr == 8'h7c |=> o_burst_start)
		else $error("no burst");
	a_burst_cause: assert property (o_burst_start |-> $past(i_rd) && $past(i_addr) == 8'h7c)
		else $error("stray burst");
	a_low_hole: assert property (i_rd && i_addr inside {[8'h02:8'h4b]} |=> o_rdata == 16'h0000)
		else $error("low hole");
	a_high_hole: assert property (i_rd && i_addr inside {[8'h58:8'h63]} |=> o_rdata == 16'h0000)
		else $error("high hole");
	a_tick_gate: assert property (!i_ext_select |-> !o_sample_tick)
		else $error("tick ungated");
endmodule // dvo_props
bind dvo_top dvo_props i_dvo_props (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_addr(i_addr),
	.i_rd(i_rd), .i_ext_select(i_ext_select), .o_rdata(o_rdata), .o_burst_start(o_burst_start),
	.o_sample_tick(o_sample_tick));
`default_nettype wire

/* File: tb/dvo_host.sv */
// Host model issuing register reads and writes.
`timescale 1ns/1ps
`default_nettype none
module dvo_host (
	input wire logic i_clock, // clock
	output logic [7:0] o_addr, // address
	output logic [15:0] o_wdata, // data
	output logic o_wr, // write
	output logic o_rd // read
);
	initial {o_addr, o_wdata, o_wr, o_rd} = '0;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clock);
		{o_addr, o_wdata, o_wr, o_rd} <= {a, d, w, !w};
		@(posedge i_clock);
		// Released address and data go inverted and the strobes go low, so a stale address cannot pass for a held one.
		{o_addr, o_wdata, o_wr, o_rd} <= {~a, ~d, 2'b00};
	endtask
endmodule // dvo_host
`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the delta velocity output block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, rst_n = 0, sv = 0, wr, rd;
	logic ec = 0, es = 0, st, bs, rv;
	int n_tick = 0, n_burst = 0, n_res = 0;
	logic signed [15:0] ax = 0, ay = 0, v, px = 0, py = 0;
	logic [7:0] ad;
	logic [15:0] wd, rq;
	logic [31:0] s = 79;
	logic [31:0] ex [3];
	longint sx, sy;
	int error_cnt = 0, n_checks = 0, cyc = 0;
	dvo_top i_dvo_top (.i_clock(clk), .i_rst_n(rst_n), .i_sample_valid(sv), .i_accel_x(ax),
		.i_accel_y(ay), .i_accel_z(ax), .i_ext_clock(ec), .i_ext_select(es), .i_addr(ad),
		.i_wdata(wd), .i_wr(wr), .i_rd(rd), .o_rdata(rq), .o_burst_start(bs), .o_sample_tick(st),
		.o_result_valid(rv));
	dvo_host i_dvo_host (.i_clock(clk), .o_addr(ad), .o_wdata(wd), .o_wr(wr), .o_rd(rd));
	initial forever #12.5 clk = ~clk;
	function automatic logic [15:0] nx();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s[15:0];
	endfunction
	task automatic wrap_up();
		$display("checks %0d errors %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [15:0] e);
		i_dvo_host.xfer(1'b0, a, 16'h0000);
		#1;
		n_checks++;
		if (rq !== e)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, rq, e);
		end
	endtask
	task automatic cmpn(input int got, input int e);
		n_checks++;
		if (got !== e)
		begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, got, e);
		end
	endtask
	task automatic chk_axes();
		ex = '{32'(sx >>> 16), 32'(sy >>> 16), 32'(sx >>> 16)};
		for (int i = 0; i < 6; i++)
			rdc(8'h4c + 8'(2 * i), 16'(ex[i / 2] >> (16 * (i % 2))));
	endtask
	task automatic feed(input logic signed [15:0] w, input bit gap);
		@(posedge clk);
		{sv, ax, ay} <= {1'b1, w, ~w};
		sx += w + px;
		sy += ~w + py;
		px = w;
		py = ~w;
		if (gap)
		begin
			@(posedge clk);
			{sv, ax, ay} <= {1'b0, ~w, w};
		end
	endtask
	task automatic ext_pulse();
		@(posedge clk);
		ec <= 1'b1;
		repeat (6) @(posedge clk);
		ec <= 1'b0;
		repeat (6) @(posedge clk);
	endtask
	always @(posedge clk)
	begin
		if (rst_n)
		begin
			n_tick += st;
			n_burst += bs;
			n_res += rv;
		end
		if (++cyc == 8000)
		begin
			error_cnt++;
			wrap_up();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rst_n <= 1;
		i_dvo_host.xfer(1'b1, dvo_pkg::DVO_OFS_DECIM, 16'h0003);
		for (int k = 0; k < 5; k++)
		begin
			sx = 0;
			sy = 0;
			repeat (4)
			begin
				v = k % 3 == 1 ? 16'h7fff : k % 3 == 2 ? 16'h8000 : nx();
				feed(v, 1'b1);
			end
			i_dvo_host.xfer(1'b1, 8'h4e, 16'h1234);
			if (k > 0)
				chk_axes();
		end
		i_dvo_host.xfer(1'b1, dvo_pkg::DVO_OFS_DECIM, dvo_pkg::DVO_DECIM_1HZ);
		sx = 0;
		sy = 0;
		repeat (int'(dvo_pkg::DVO_DECIM_1HZ) + 1)
			feed(16'sh7fff, 1'b0);
		@(posedge clk);
		sv <= 1'b0;
		chk_axes();
		repeat (2) rdc(dvo_pkg::DVO_OFS_PART_ID, dvo_pkg::DVO_PART_ID_VALUE);
		rdc(dvo_pkg::DVO_OFS_TRIGGER, dvo_pkg::DVO_TRIGGER_VALUE);
		rdc(8'h20, 16'h0000);
		rdc(8'h5a, 16'h0000);
		@(posedge clk);
		es <= 1'b1;
		repeat (3) ext_pulse();
		@(posedge clk);
		es <= 1'b0;
		ext_pulse();
		cmpn(n_tick, 3);
		cmpn(n_burst, 1);
		cmpn(n_res, 6);
		wrap_up();
	end
endmodule // tb_top
`default_nettype wire
